// ==== rtl/fpec_pkg.sv ====
// Purpose: constants shared by the flash program/erase controller
// Assumes: 8-bit register port, 16-bit program memory address
// Notes: register indices are byte offsets on the local register port
package fpec_pkg;
   // register offsets
   localparam logic [1:0] FPEC_CMD_ADDR = 2'h0;   // command write / state read
   localparam logic [1:0] FPEC_PAGE_ADDR = 2'h1;  // page select / sector guard
   localparam logic [1:0] FPEC_KHZ_HI_ADDR = 2'h2;
   localparam logic [1:0] FPEC_KHZ_LO_ADDR = 2'h3;
   // command codes
   localparam logic [7:0] FPEC_CMD_UNLOCK1 = 8'h73;
   localparam logic [7:0] FPEC_CMD_UNLOCK2 = 8'h8c;
   localparam logic [7:0] FPEC_CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] FPEC_CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0] FPEC_CMD_GUARD = 8'h5e;
   // state field codes
   localparam logic [5:0] FPEC_ST_LOCKED = 6'h00;
   localparam logic [5:0] FPEC_ST_FIRST = 6'h01;
   localparam logic [5:0] FPEC_ST_SECOND = 6'h02;
   localparam logic [5:0] FPEC_ST_UNLOCKED = 6'h03;
   localparam logic [5:0] FPEC_ST_GUARD = 6'h04;
   localparam logic [5:0] FPEC_ST_PROG = 6'h08;
   localparam logic [5:0] FPEC_ST_PERASE = 6'h10;
   localparam logic [5:0] FPEC_ST_MERASE = 6'h20;
   // reset values
   localparam logic [7:0] FPEC_PAGE_RST = 8'h00;
   localparam logic [7:0] FPEC_GUARD_RST = 8'h00;
   localparam logic [15:0] FPEC_KHZ_RST = 16'h0000;
   localparam logic [7:0] FPEC_ERASED = 8'hff;
   // field positions
   localparam int FPEC_PAGE_MSB = 6;
   localparam int FPEC_ADDR_PAGE_LSB = 9;
   localparam int FPEC_PAGE_BYTES = 512;
   // operation times in microseconds; scaled by the loaded kHz value
   localparam logic [15:0] FPEC_PROG_US = 16'd40;
   localparam logic [15:0] FPEC_PERASE_US = 16'd10000;
   localparam logic [15:0] FPEC_MERASE_US = 16'd20000;
   localparam int FPEC_US_PER_MS = 1000;
endpackage : fpec_pkg

// ==== rtl/fpec_timer.sv ====
// Purpose: operation duration counter for program and erase
// Assumes: khz_i holds the system clock in kHz
// Notes: one microsecond tick is made from khz/1000 clock cycles
`timescale 1ns/10ps
`default_nettype none
module fpec_timer
   import fpec_pkg::*;
(
   input wire logic mclk_i,            // system clock
   input wire logic rst_n_i,           // async reset, active low
   input wire logic start_i,           // start pulse
   input wire logic [15:0] khz_i,      // clock frequency in kHz
   input wire logic [15:0] dur_us_i,   // duration in microseconds
   output logic done_o                 // one-cycle end pulse
);
   logic [15:0] cyc;
   logic [15:0] us_left;
   logic running;
   logic [15:0] us_cycles;
   wire tick = running && (cyc == 16'h0000);

   // cycles per microsecond, at least one
   assign us_cycles = (khz_i < 16'd2000) ? 16'h0001 : khz_i / 16'd1000;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc <= 16'h0000;
         us_left <= 16'h0000;
         running <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            running <= 1'b1;
            cyc <= us_cycles - 16'h0001;
            us_left <= (dur_us_i == 16'h0000) ? 16'h0001 : dur_us_i;
         end else if (tick) begin
            cyc <= us_cycles - 16'h0001;
            us_left <= us_left - 16'h0001;
            if (us_left == 16'h0001) begin
               running <= 1'b0;
               done_o <= 1'b1;
            end
         end else if (running) begin
            cyc <= cyc - 16'h0001;
         end
      end
   end
endmodule : fpec_timer
`default_nettype wire

// ==== rtl/fpec_ctrl.sv ====
// Purpose: flash program/erase controller with lock sequence and protection
// Assumes: flash array on the far side with write, page erase, mass erase strobes
// Notes: debugger_port_i marks the current access as coming from the debugger
// How it works
// - reset puts the controller in locked state.
// - second page write must match first or controller relocks.
// - 95H from CPU starts page erase only when page's sector is unguarded.
// - any other command write while unlocked relocks and ends programming.
// - byte writes within open page accepted; page stays open.
// - one open page; any command write closes it.
// - mass erase refused from CPU, honoured from debugger.
// - 73H then 5EH redirects next page-address write to sector guard.
// - guard bits reset to zero; set bit blocks CPU program/erase.
// - CPU cannot clear a set guard bit until power down.
// - up to eight sectors, each one eighth, never below one page.
// - page erase erases selected page; mass erase erases everything.
// - erased bytes read FFH; programming outside bypass only clears bits.
// - core stalled during program and erase operations while debugger_port_i is low.
// - page erase fills 512 bytes with FFH then relocks.
// - debugger 63H on unlocked controller mass erases then relocks.
// - debugger ignores write enable option, guards and page limit.
// - debugger skips second page write, may reselect, clear guards, mass erase.
// - write enable option zero disables CPU program and erase.
// - read protect option blocks debugger reads of program flash.
// - bypass mode routes array controls to pins; page erase allowed.
// - state field reports six-bit state codes.
// - invalid commands or order return to locked.
// - page field gives program address bits 15 to 9.
`timescale 1ns/10ps
`default_nettype none
module fpec_ctrl
   import fpec_pkg::*;
#(
   parameter int PAGES = 16            // pages in the array
)(
   input wire logic mclk_i,            // system clock
   input wire logic rst_n_i,           // async reset, active low
   input wire logic [1:0] reg_addr_i,  // register address
   input wire logic [7:0] reg_wdata_i, // register write data
   input wire logic reg_wr_i,          // register write strobe
   input wire logic reg_rd_i,          // register read strobe
   output logic [7:0] reg_rdata_o,     // read data, cycle after strobe
   input wire logic debugger_port_i,   // access comes from debugger
   input wire logic write_enable_option_i, // write enable option bit
   input wire logic read_protect_option_i, // read protect option bit
   input wire logic bypass_i,          // bypass mode select
   input wire logic mem_wr_i,          // program memory byte store
   input wire logic mem_rd_i,          // program memory read request
   input wire logic [15:0] mem_addr_i, // program memory address
   input wire logic [7:0] mem_wdata_i, // program memory store data
   input wire logic [7:0] arr_rdata_i, // current array byte at mem_addr_i
   input wire logic byp_prog_i,        // bypass pin: program strobe
   input wire logic byp_erase_i,       // bypass pin: page erase strobe
   input wire logic [15:0] byp_addr_i, // bypass pin: address
   input wire logic [7:0] byp_data_i,  // bypass pin: data
   output logic arr_prog_o,            // array byte program strobe
   output logic arr_page_erase_o,      // array page erase strobe
   output logic arr_mass_erase_o,      // array mass erase strobe
   output logic [15:0] arr_addr_o,     // array address
   output logic [7:0] arr_data_o,      // array data, bits only cleared outside bypass
   output logic cpu_stall_o,           // holds the core during operations, not on debugger access
   output logic read_blocked_o,        // debugger read refused
   output logic [5:0] state_o          // controller state field
);
   typedef enum {S_LOCKED, S_FIRST, S_SECOND, S_PAGE_WAIT, S_UNLOCKED, S_GUARD_SEL,
                 S_PROG, S_PERASE, S_MERASE} fpec_state_type;

   fpec_state_type state;
   fpec_state_type next_state;
   logic [7:0] page_sel;
   logic [7:0] next_page_sel;
   logic [7:0] guard;
   logic [7:0] next_guard;
   logic [15:0] khz;
   logic page_open;
   logic next_page_open;
   logic all_open;
   logic next_all_open;
   logic timer_start;
   logic [15:0] timer_dur;
   logic timer_done;
   logic [7:0] op_data;
   logic [5:0] state_code;

   ////////////////////////////////////////////////////////////////////////////
   // sector of a page: eight sectors, never smaller than a page
   function automatic logic [2:0] sector_of(input logic [7:0] pg);
      logic [7:0] per;
      per = (PAGES >= 8) ? 8'(PAGES / 8) : 8'h01;
      return 3'(pg[FPEC_PAGE_MSB:0] / per);
   endfunction : sector_of

   // permission for a page given the source of the access
   function automatic logic page_allowed(input logic [7:0] pg, input logic [7:0] g,
                                         input logic dbg, input logic wen);
      return dbg || (wen && !g[sector_of(pg)]);
   endfunction : page_allowed

   ////////////////////////////////////////////////////////////////////////////
   wire cmd_wr = reg_wr_i && (reg_addr_i == FPEC_CMD_ADDR);
   wire page_wr = reg_wr_i && (reg_addr_i == FPEC_PAGE_ADDR);
   wire hi_wr = reg_wr_i && (reg_addr_i == FPEC_KHZ_HI_ADDR);
   wire lo_wr = reg_wr_i && (reg_addr_i == FPEC_KHZ_LO_ADDR);
   wire busy = (state == S_PROG) || (state == S_PERASE) || (state == S_MERASE);
   wire [7:0] mem_page = {1'b0, mem_addr_i[15:FPEC_ADDR_PAGE_LSB]};
   wire in_page = (mem_page[FPEC_PAGE_MSB:0] == page_sel[FPEC_PAGE_MSB:0]);
   wire may_prog = all_open || (page_open && (in_page || debugger_port_i)) ;
   wire prog_ok = (state == S_UNLOCKED) && mem_wr_i && may_prog &&
                  page_allowed(mem_page, guard, debugger_port_i, write_enable_option_i);
   wire erase_ok = page_allowed(page_sel, guard, debugger_port_i, write_enable_option_i);

   assign op_data = bypass_i ? byp_data_i : (arr_rdata_i & mem_wdata_i);

   ////////////////////////////////////////////////////////////////////////////
   // lock sequencer
   always_comb begin
      next_state = state;
      next_page_sel = page_sel;
      next_guard = guard;
      next_page_open = page_open;
      next_all_open = all_open;
      timer_start = 1'b0;
      timer_dur = FPEC_PROG_US;
      case (state)
         S_LOCKED: begin
            next_page_open = 1'b0;
            next_all_open = 1'b0;
            if (cmd_wr && reg_wdata_i == FPEC_CMD_UNLOCK1) begin
               next_state = S_FIRST;
            end
            if (page_wr) begin
               next_page_sel = reg_wdata_i;
            end
         end
         S_FIRST: begin
            if (cmd_wr && reg_wdata_i == FPEC_CMD_UNLOCK2) begin
               next_state = S_SECOND;
            end else if (cmd_wr && reg_wdata_i == FPEC_CMD_GUARD) begin
               next_state = S_GUARD_SEL;
            end else if (cmd_wr || page_wr) begin
               next_state = S_LOCKED;
            end
         end
         S_SECOND: begin
            if (debugger_port_i) begin
               next_state = S_UNLOCKED;
               next_page_open = 1'b1;
               if (page_wr) begin
                  next_page_sel = reg_wdata_i;
               end
            end else if (page_wr) begin
               if (reg_wdata_i == page_sel) begin
                  next_state = S_UNLOCKED;
                  next_page_open = 1'b1;
               end else begin
                  next_state = S_LOCKED;
               end
            end else if (cmd_wr) begin
               next_state = S_LOCKED;
            end
         end
         S_GUARD_SEL: begin
            if (page_wr) begin
               // cpu can only set guard bits, debugger may also clear them
               next_guard = debugger_port_i ? reg_wdata_i : (guard | reg_wdata_i);
               next_state = S_LOCKED;
            end else if (cmd_wr) begin
               next_state = S_LOCKED;
            end
         end
         S_UNLOCKED: begin
            if (page_wr && debugger_port_i) begin
               next_page_sel = reg_wdata_i;
            end
            if (cmd_wr) begin
               next_page_open = 1'b0;
               if (reg_wdata_i == FPEC_CMD_PAGE_ERASE && page_open && erase_ok) begin
                  next_state = S_PERASE;
                  timer_start = 1'b1;
                  timer_dur = FPEC_PERASE_US;
               end else if (reg_wdata_i == FPEC_CMD_MASS_ERASE && debugger_port_i) begin
                  next_state = S_MERASE;
                  timer_start = 1'b1;
                  timer_dur = FPEC_MERASE_US;
               end else begin
                  next_state = S_LOCKED;
               end
            end else if (prog_ok) begin
               next_state = S_PROG;
               timer_start = 1'b1;
            end
         end
         S_PROG: begin
            if (timer_done) begin
               next_state = S_UNLOCKED;
            end
         end
         S_PERASE: begin
            if (timer_done) begin
               next_state = S_LOCKED;
            end
         end
         S_MERASE: begin
            if (timer_done) begin
               next_state = S_LOCKED;
            end
         end
         default: next_state = S_LOCKED;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= S_LOCKED;
         page_sel <= FPEC_PAGE_RST;
         guard <= FPEC_GUARD_RST;
         page_open <= 1'b0;
         all_open <= 1'b0;
      end else begin
         state <= next_state;
         page_sel <= next_page_sel;
         guard <= next_guard;
         page_open <= next_page_open;
         all_open <= next_all_open;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         khz <= FPEC_KHZ_RST;
      end else if (hi_wr) begin
         khz[15:8] <= reg_wdata_i;
      end else if (lo_wr) begin
         khz[7:0] <= reg_wdata_i;
      end
   end

   fpec_timer u_timer (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .start_i(timer_start),
      .khz_i(khz),
      .dur_us_i(timer_dur),
      .done_o(timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // array strobes
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arr_prog_o <= 1'b0;
         arr_page_erase_o <= 1'b0;
         arr_mass_erase_o <= 1'b0;
         arr_addr_o <= 16'h0000;
         arr_data_o <= FPEC_ERASED;
      end else if (bypass_i) begin
         arr_prog_o <= byp_prog_i;
         arr_page_erase_o <= byp_erase_i;
         arr_mass_erase_o <= 1'b0;
         arr_addr_o <= byp_addr_i;
         arr_data_o <= op_data;
      end else begin
         arr_prog_o <= (state == S_UNLOCKED) && (next_state == S_PROG);
         arr_page_erase_o <= (state == S_UNLOCKED) && (next_state == S_PERASE);
         arr_mass_erase_o <= (state == S_UNLOCKED) && (next_state == S_MERASE);
         if (prog_ok) begin
            arr_addr_o <= mem_addr_i;
            arr_data_o <= op_data;
         end else if (next_state == S_PERASE && state == S_UNLOCKED) begin
            arr_addr_o <= {page_sel[FPEC_PAGE_MSB:0], 9'h000};
            arr_data_o <= FPEC_ERASED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state field and register read
   assign state_code = (state == S_LOCKED) ? FPEC_ST_LOCKED :
                       (state == S_FIRST) ? FPEC_ST_FIRST :
                       (state == S_SECOND) ? FPEC_ST_SECOND :
                       (state == S_UNLOCKED) ? FPEC_ST_UNLOCKED :
                       (state == S_GUARD_SEL) ? FPEC_ST_GUARD :
                       (state == S_PROG) ? FPEC_ST_PROG :
                       (state == S_PERASE) ? FPEC_ST_PERASE : FPEC_ST_MERASE;
   assign state_o = state_code;
   assign cpu_stall_o = busy && !debugger_port_i;
   assign read_blocked_o = mem_rd_i && debugger_port_i && read_protect_option_i;

   wire [7:0] rd_mux = (reg_addr_i == FPEC_CMD_ADDR) ? {2'b00, state_code} :
                       (reg_addr_i == FPEC_PAGE_ADDR) ?
                          ((state == S_GUARD_SEL) ? guard : page_sel) :
                       (reg_addr_i == FPEC_KHZ_HI_ADDR) ? khz[15:8] : khz[7:0];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end
endmodule : fpec_ctrl
`default_nettype wire

// ==== dv/fpec_ctrl_properties.sv ====
// Purpose: port-level properties of the flash program/erase controller
// Assumes: one clock domain, async active-low reset
// Notes: bound to every fpec_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module fpec_ctrl_properties
   import fpec_pkg::*;
#(
   parameter int PAGES = 16                 // pages in the array
)(
   input wire logic mclk_i,                 // system clock
   input wire logic rst_n_i,                // async reset, active low
   input wire logic [1:0] reg_addr_i,       // register address
   input wire logic [7:0] reg_wdata_i,      // register write data
   input wire logic reg_wr_i,               // write strobe
   input wire logic reg_rd_i,               // read strobe
   input wire logic [7:0] reg_rdata_o,      // read data
   input wire logic debugger_port_i,        // debugger access
   input wire logic read_protect_option_i,  // read protect option
   input wire logic bypass_i,               // bypass select
   input wire logic mem_rd_i,               // memory read request
   input wire logic [7:0] mem_wdata_i,      // store data
   input wire logic [7:0] arr_rdata_i,      // current array byte
   input wire logic arr_prog_o,             // program strobe
   input wire logic arr_page_erase_o,       // page erase strobe
   input wire logic arr_mass_erase_o,       // mass erase strobe
   input wire logic [7:0] arr_data_o,       // array data
   input wire logic cpu_stall_o,            // core stall
   input wire logic read_blocked_o,         // debugger read refused
   input wire logic [5:0] state_o           // state field
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic cmd_wr = reg_wr_i && reg_addr_i == FPEC_CMD_ADDR;
   ////////////////////////////////////////////////////////////////////////////////
   AST_RESET_LOCKED: assert property ($rose(rst_n_i) |-> state_o == FPEC_ST_LOCKED)
      else $error("state not locked after reset");
   AST_STATE_READ: assert property (reg_rd_i && reg_addr_i == FPEC_CMD_ADDR
      |=> reg_rdata_o == {2'h0, $past(state_o)}) else $error("state read wrong");
   AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero when idle");
   AST_FIRST_CODE: assert property (state_o == FPEC_ST_LOCKED && cmd_wr
      && reg_wdata_i == FPEC_CMD_UNLOCK1 |=> state_o == FPEC_ST_FIRST) else $error("no first code");
   AST_SECOND_CODE: assert property (state_o == FPEC_ST_FIRST && cmd_wr
      && reg_wdata_i == FPEC_CMD_UNLOCK2 |=> state_o == FPEC_ST_SECOND)
      else $error("second code step wrong");
   AST_GUARD_SEL: assert property (state_o == FPEC_ST_FIRST && cmd_wr
      && reg_wdata_i == FPEC_CMD_GUARD |=> state_o == FPEC_ST_GUARD) else $error("no guard select");
   AST_RELOCK: assert property (state_o == FPEC_ST_UNLOCKED && cmd_wr
      && reg_wdata_i != FPEC_CMD_PAGE_ERASE && reg_wdata_i != FPEC_CMD_MASS_ERASE
      |=> state_o == FPEC_ST_LOCKED) else $error("no relock on other command");
   AST_MASS_DEBUG: assert property (arr_mass_erase_o |-> $past(debugger_port_i))
      else $error("mass erase without debugger");
   AST_ERASE_STATE: assert property (arr_page_erase_o && !$past(bypass_i)
      |-> state_o == FPEC_ST_PERASE) else $error("page erase outside erase state");
   AST_PERASE_END: assert property (state_o == FPEC_ST_PERASE ##1 state_o != FPEC_ST_PERASE
      |-> state_o == FPEC_ST_LOCKED) else $error("page erase did not relock");
   AST_STALL: assert property (cpu_stall_o == (state_o[5:3] != 3'h0 && !debugger_port_i))
      else $error("stall does not match busy");
   AST_READ_BLOCK: assert property (read_blocked_o ==
      (mem_rd_i && debugger_port_i && read_protect_option_i)) else $error("read block wrong");
   AST_BIT_CLEAR: assert property (arr_prog_o && !$past(bypass_i)
      |-> arr_data_o == ($past(mem_wdata_i) & $past(arr_rdata_i))) else $error("bits set");
   COV_PAGE_ERASE: cover property (arr_page_erase_o && state_o == FPEC_ST_PERASE);
   COV_MASS_ERASE: cover property (arr_mass_erase_o);
   COV_GUARD: cover property (state_o == FPEC_ST_GUARD);
endmodule : fpec_ctrl_properties

bind fpec_ctrl fpec_ctrl_properties #(.PAGES(PAGES)) fpec_ctrl_properties_i (.*);
`default_nettype wire

// ==== dv/fpec_flash_model.sv ====
// Purpose: behavioural flash array behind the controller
// Assumes: 8 KB array, page of 512 bytes
// Notes: stores whatever data the controller hands over
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model (
   input wire logic mclk_i,             // system clock
   input wire logic prog_i,             // byte program strobe
   input wire logic page_erase_i,       // page erase strobe
   input wire logic mass_erase_i,       // mass erase strobe
   input wire logic [15:0] addr_i,      // array address
   input wire logic [7:0] data_i,       // program data
   input wire logic [15:0] rd_addr_i,   // read address
   output logic [7:0] rdata_o           // byte at read address
);
   logic [7:0] cells [0:8191];
   assign rdata_o = cells[rd_addr_i[12:0]];
   initial begin
      for (int i = 0; i < 8192; i++) cells[i] = 8'hff;
   end
   always @(posedge mclk_i) begin
      if (prog_i) cells[addr_i[12:0]] <= data_i;
      if (page_erase_i) for (int i = 0; i < 512; i++) cells[{addr_i[12:9], 9'h000} + 13'(i)] <= 8'hff;
      if (mass_erase_i) for (int i = 0; i < 8192; i++) cells[i] <= 8'hff;
   end
endmodule : fpec_flash_model
`default_nettype wire

// ==== dv/fpec_ctrl_tb.sv ====
// Purpose: self-checking bench of the flash program/erase controller
// Assumes: kHz value 0, so one cycle per microsecond of operation time
// Notes: strobe pulses are counted at every rising edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module fpec_ctrl_tb
   import fpec_pkg::*;
;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, mem_wr_i = 1'b0;
   logic debugger_port_i = 1'b0, write_enable_option_i = 1'b1, read_protect_option_i = 1'b0;
   logic bypass_i = 1'b0, mem_rd_i = 1'b0, byp_prog_i = 1'b0, byp_erase_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00, mem_wdata_i = 8'h00, byp_data_i = 8'h00;
   logic [15:0] mem_addr_i = 16'h0000, byp_addr_i = 16'h0000;
   logic [7:0] reg_rdata_o, arr_rdata_i, arr_data_o;
   logic arr_prog_o, arr_page_erase_o, arr_mass_erase_o, cpu_stall_o, read_blocked_o;
   logic [15:0] arr_addr_o;
   logic [5:0] state_o;
   int num_errors = 0, total_checks = 0, cycles = 0, n_prog = 0, n_pe = 0, n_me = 0;
   fpec_ctrl #(.PAGES(16)) fpec_ctrl_i (.*);
   fpec_flash_model fpec_flash_model_i (.mclk_i(mclk_i), .prog_i(arr_prog_o),
      .page_erase_i(arr_page_erase_o), .mass_erase_i(arr_mass_erase_o), .addr_i(arr_addr_o),
      .data_i(arr_data_o), .rd_addr_i(mem_addr_i), .rdata_o(arr_rdata_i));
   ////////////////////////////////////////////////////////////////////////////////
   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (arr_prog_o === 1'b1) n_prog++;
      if (arr_page_erase_o === 1'b1) n_pe++;
      if (arr_mass_erase_o === 1'b1) n_me++;
      if (cycles == 60000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask : wr
   task automatic rd(input logic [5:0] e);
      reg_addr_i <= FPEC_CMD_ADDR;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(negedge mclk_i);
      `CHK("state", {2'h0, e}, reg_rdata_o)
      @(posedge mclk_i);
   endtask : rd
   task automatic settle();
      @(negedge mclk_i);
      for (int i = 0; i < 30000 && state_o[5:3] != 3'h0; i++) @(negedge mclk_i);
      `CHK("busy", 3'h0, state_o[5:3])
      @(posedge mclk_i);
   endtask : settle
   task automatic open_page(input logic [7:0] p);
      wr(FPEC_PAGE_ADDR, p);
      wr(FPEC_CMD_ADDR, FPEC_CMD_UNLOCK1);
      wr(FPEC_CMD_ADDR, FPEC_CMD_UNLOCK2);
      if (debugger_port_i !== 1'b1) wr(FPEC_PAGE_ADDR, p);
   endtask : open_page
   task automatic guard(input logic [7:0] g);
      wr(FPEC_CMD_ADDR, FPEC_CMD_UNLOCK1);
      wr(FPEC_CMD_ADDR, FPEC_CMD_GUARD);
      wr(FPEC_PAGE_ADDR, g);
      wr(FPEC_CMD_ADDR, 8'h00);
   endtask : guard
   task automatic store(input logic [15:0] a, input logic [7:0] d, input int ok);
      int n;
      n = n_prog;
      mem_addr_i <= a;
      mem_wdata_i <= d;
      mem_wr_i <= 1'b1;
      @(posedge mclk_i);
      mem_wr_i <= 1'b0;
      settle();
      `CHK("program", n + ok, n_prog)
   endtask : store
   task automatic peek(input logic [15:0] a, input logic [7:0] e);
      mem_addr_i <= a;
      @(negedge mclk_i);
      `CHK("cell", e, arr_rdata_i)
      @(posedge mclk_i);
   endtask : peek
   task automatic cmd(input logic [7:0] c, input int pe, input int me);
      int a, b;
      a = n_pe;
      b = n_me;
      wr(FPEC_CMD_ADDR, c);
      @(negedge mclk_i);
      `CHK("stall", ((pe + me) > 0 && debugger_port_i !== 1'b1), cpu_stall_o)
      settle();
      `CHK("page erase", a + pe, n_pe)
      `CHK("mass erase", b + me, n_me)
   endtask : cmd
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      rd(FPEC_ST_LOCKED);
      wr(FPEC_KHZ_HI_ADDR, 8'h00);
      wr(FPEC_KHZ_LO_ADDR, 8'h00);
      wr(FPEC_PAGE_ADDR, 8'h05);
      wr(FPEC_CMD_ADDR, FPEC_CMD_UNLOCK1);
      rd(FPEC_ST_FIRST);
      wr(FPEC_CMD_ADDR, FPEC_CMD_UNLOCK2);
      rd(FPEC_ST_SECOND);
      wr(FPEC_PAGE_ADDR, 8'h06);
      rd(FPEC_ST_LOCKED);
      open_page(8'h05);
      rd(FPEC_ST_UNLOCKED);
      store(16'h0a10, 8'hf0, 1);
      store(16'h0a10, 8'h3c, 1);
      store(16'h0bff, 8'h00, 1);
      store(16'h0c00, 8'h00, 0);
      peek(16'h0a10, 8'h30);
      cmd(FPEC_CMD_PAGE_ERASE, 1, 0);
      rd(FPEC_ST_LOCKED);
      peek(16'h0a10, FPEC_ERASED);
      peek(16'h0bff, FPEC_ERASED);
      open_page(8'h05);
      cmd(8'h42, 0, 0);
      rd(FPEC_ST_LOCKED);
      store(16'h0a00, 8'h00, 0);
      open_page(8'h05);
      cmd(FPEC_CMD_MASS_ERASE, 0, 0);
      wr(FPEC_CMD_ADDR, 8'h00);
      write_enable_option_i <= 1'b0;
      open_page(8'h05);
      store(16'h0a20, 8'h00, 0);
      cmd(FPEC_CMD_PAGE_ERASE, 0, 0);
      wr(FPEC_CMD_ADDR, 8'h00);
      write_enable_option_i <= 1'b1;
      wr(FPEC_CMD_ADDR, FPEC_CMD_UNLOCK1);
      wr(FPEC_CMD_ADDR, FPEC_CMD_GUARD);
      rd(FPEC_ST_GUARD);
      wr(FPEC_PAGE_ADDR, 8'h04);
      wr(FPEC_CMD_ADDR, 8'h00);
      guard(8'h00);
      open_page(8'h05);
      store(16'h0a30, 8'h00, 0);
      cmd(FPEC_CMD_PAGE_ERASE, 0, 0);
      wr(FPEC_CMD_ADDR, 8'h00);
      open_page(8'h06);
      store(16'h0c00, 8'h5a, 1);
      wr(FPEC_CMD_ADDR, 8'h00);
      debugger_port_i <= 1'b1;
      write_enable_option_i <= 1'b0;
      open_page(8'h05);
      rd(FPEC_ST_UNLOCKED);
      store(16'h0a40, 8'h00, 1);
      store(16'h1000, 8'h00, 1);
      cmd(FPEC_CMD_MASS_ERASE, 0, 1);
      rd(FPEC_ST_LOCKED);
      peek(16'h1000, FPEC_ERASED);
      guard(8'h00);
      debugger_port_i <= 1'b0;
      write_enable_option_i <= 1'b1;
      open_page(8'h05);
      cmd(FPEC_CMD_PAGE_ERASE, 1, 0);
      read_protect_option_i <= 1'b1;
      mem_rd_i <= 1'b1;
      debugger_port_i <= 1'b1;
      @(negedge mclk_i);
      `CHK("read block", 1'b1, read_blocked_o)
      @(posedge mclk_i);
      debugger_port_i <= 1'b0;
      @(negedge mclk_i);
      `CHK("read block", 1'b0, read_blocked_o)
      @(posedge mclk_i);
      store(16'h0c00, 8'h5a, 0);
      bypass_i <= 1'b1;
      byp_addr_i <= 16'h0c00;
      byp_erase_i <= 1'b1;
      @(posedge mclk_i);
      byp_erase_i <= 1'b0;
      @(negedge mclk_i);
      `CHK("bypass erase", 1'b1, arr_page_erase_o)
      @(posedge mclk_i);
      peek(16'h0c00, FPEC_ERASED);
      wrap_up();
   end
endmodule : fpec_ctrl_tb
`default_nettype wire
